// ==== ir_counter_control.sv ====
// control logic for the short and long infrared counters, AHB-Lite slave
// assumes one 40 MHz clock, an external short counter datapath giving
// short_terminal pulses, and synchronous pin inputs
`timescale 1ns/100ps
`default_nettype none

module ir_counter_control (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        stop_recovery,
  input  wire logic        short_terminal,
  input  wire logic        demod_input_a,
  input  wire logic        demod_input_b,
  input  wire logic        port_data,
  output var  logic        short_counter_output,
  output var  logic        long_counter_output,
  output var  logic        combined_output,
  output var  logic        long_pin,
  output var  logic        capture_request,
  output var  logic        timeout_request
);
  import ir_counter_pkg::*;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wr_pend_reg;
  logic [5:0]  wr_idx_reg;
  wire         addr_ok;
  wire  [5:0]  rd_idx;
  wire  [7:0]  wbyte;
  wire         wr_short;
  wire         wr_common;
  wire         wr_long;
  wire         wr_reload;
  wire  [31:0] rd_value;

  assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'b11);
  assign rd_idx    = haddr[7:2];
  assign wbyte     = hwdata[7:0];
  assign wr_short  = wr_pend_reg && (wr_idx_reg == IDX_SHORT_CTRL);
  assign wr_common = wr_pend_reg && (wr_idx_reg == IDX_COMMON);
  assign wr_long   = wr_pend_reg && (wr_idx_reg == IDX_LONG_CTRL);
  assign wr_reload = wr_pend_reg && (wr_idx_reg == IDX_LONG_RELOAD);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 6'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_idx_reg  <= addr_ok ? rd_idx : wr_idx_reg;
      hrdata      <= (addr_ok && !hwrite) ? rd_value : hrdata;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic        short_enable_reg;
  logic [6:0]  short_spare_reg;
  logic        mode_reg;
  logic        in_sel_reg;
  logic [1:0]  sel_reg;
  logic [1:0]  sub_reg;
  logic        short_init_or_rise_flag_reg;
  logic        long_init_or_fall_flag_reg;
  logic        long_run_enable_reg;
  logic        single_reg;
  logic        timeout_reg;
  logic [1:0]  long_prescale_select_reg;
  logic        cap_mask_reg;
  logic        to_mask_reg;
  logic        long_pin_output_select_reg;
  logic [15:0] reload_reg;
  logic [15:0] capture_reg;
  logic [15:0] count_reg;
  logic        long_en_d_reg;
  logic        short_en_d_reg;
  turn_t       turn_reg;

  wire         demod;
  wire         pingpong;
  wire         forced;
  wire         rise_evt;
  wire         fall_evt;
  wire         tick;
  wire         edge_evt;
  wire         long_start;
  wire         short_start;
  wire         allowed;
  wire         terminal;
  wire         single_stop;
  wire         capture_evt;
  wire         clr_rise;
  wire         clr_fall;
  wire         clr_timeout;

  assign demod    = mode_reg;
  assign pingpong = !demod && (sub_reg == SUB_PINGPONG);
  assign forced   = !demod && (sub_reg == SUB_FORCE_LOW || sub_reg == SUB_FORCE_HIGH);

  assign rd_value =
    (rd_idx == IDX_SHORT_CTRL)  ? {24'h000000, short_enable_reg, short_spare_reg} :
    (rd_idx == IDX_COMMON)      ? {24'h000000, mode_reg, in_sel_reg, sel_reg, sub_reg,
                                   short_init_or_rise_flag_reg,
                                   long_init_or_fall_flag_reg} :
    (rd_idx == IDX_LONG_CTRL)   ? {24'h000000, long_run_enable_reg, single_reg, timeout_reg,
                                   long_prescale_select_reg, cap_mask_reg, to_mask_reg,
                                   long_pin_output_select_reg} :
    (rd_idx == IDX_LONG_RELOAD) ? {16'h0000, reload_reg} :
    (rd_idx == IDX_CAPTURE)     ? {16'h0000, capture_reg} : 32'h0000_0000;

  // flag clears: a set in the same cycle wins
  assign clr_rise    = wr_common && wbyte[CF_SHORT];
  assign clr_fall    = wr_common && wbyte[CF_LONG];
  assign clr_timeout = wr_long && wbyte[LC_TIMEOUT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      long_prescale_select_reg <= PRE_RESET;
      cap_mask_reg             <= 1'b0;
    end else if (wr_long) begin
      long_prescale_select_reg <= wbyte[LC_PRE_LO +: 2];
      cap_mask_reg             <= wbyte[LC_CAP_MASK];
    end
  end

  // stop recovery resets all control registers except prescale and capture mask (reload goes to 00FF)
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {short_enable_reg, short_spare_reg} <= CTRL_RESET;
      {mode_reg, in_sel_reg, sel_reg, sub_reg} <= 6'h00;
      short_init_or_rise_flag_reg <= 1'b0;
      long_init_or_fall_flag_reg  <= 1'b0;
      long_run_enable_reg         <= 1'b0;
      single_reg                  <= 1'b0;
      timeout_reg                 <= 1'b0;
      to_mask_reg                 <= 1'b0;
      long_pin_output_select_reg  <= 1'b0;
      reload_reg                  <= RELOAD_RESET;
    end else if (stop_recovery) begin
      {short_enable_reg, short_spare_reg} <= CTRL_RESET;
      {mode_reg, in_sel_reg, sel_reg, sub_reg} <= 6'h00;
      short_init_or_rise_flag_reg <= 1'b0;
      long_init_or_fall_flag_reg  <= 1'b0;
      long_run_enable_reg         <= 1'b0;
      single_reg                  <= 1'b0;
      timeout_reg                 <= 1'b0;
      to_mask_reg                 <= 1'b0;
      long_pin_output_select_reg  <= 1'b0;
      reload_reg                  <= RELOAD_RESET;
    end else begin
      if (wr_short) begin
        {short_enable_reg, short_spare_reg} <= wbyte;
      end
      if (wr_common) begin
        {mode_reg, in_sel_reg, sel_reg, sub_reg} <= wbyte[7:2];
      end
      if (demod) begin
        short_init_or_rise_flag_reg <= rise_evt | (short_init_or_rise_flag_reg & ~clr_rise);
        long_init_or_fall_flag_reg  <= fall_evt | (long_init_or_fall_flag_reg & ~clr_fall);
      end else if (wr_common) begin
        short_init_or_rise_flag_reg <= wbyte[CF_SHORT];
        long_init_or_fall_flag_reg  <= wbyte[CF_LONG];
      end
      if (wr_long) begin
        long_run_enable_reg        <= wbyte[LC_ENABLE];
        single_reg                 <= wbyte[LC_SINGLE];
        to_mask_reg                <= wbyte[LC_TO_MASK];
        long_pin_output_select_reg <= wbyte[LC_PIN_SEL];
      end else if (single_stop) begin
        long_run_enable_reg        <= 1'b0;
      end
      timeout_reg <= terminal | (timeout_reg & ~clr_timeout);
      if (wr_reload) begin
        reload_reg <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // demodulator input, prescaler
  // ----------------------------------------------------------------
  ir_edge_filter u_filter (
    .clock      (clock),
    .nrst       (nrst),
    .raw        (in_sel_reg ? demod_input_b : demod_input_a),
    .width_code (sub_reg),
    .rise       (rise_evt),
    .fall       (fall_evt)
  );

  ir_prescaler u_prescaler (
    .clock  (clock),
    .nrst   (nrst),
    .select (long_prescale_select_reg),
    .tick   (tick)
  );

  assign edge_evt = (sel_reg == EDGE_FALL) ? fall_evt :
                    (sel_reg == EDGE_RISE) ? rise_evt :
                    (sel_reg == EDGE_BOTH) ? (rise_evt | fall_evt) : 1'b0;

  // ----------------------------------------------------------------
  // long counter
  // ----------------------------------------------------------------
  assign long_start  = long_run_enable_reg && !long_en_d_reg;
  assign short_start = short_enable_reg && !short_en_d_reg;
  assign allowed     = !pingpong || (turn_reg == TURN_LONG);
  assign terminal    = long_run_enable_reg && !long_start && tick && allowed
                       && (count_reg == 16'h0000);
  assign single_stop = terminal && !demod && single_reg;
  assign capture_evt = demod && long_run_enable_reg && !single_reg && edge_evt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg      <= 16'h0000;
      capture_reg    <= 16'h0000;
      long_en_d_reg  <= 1'b0;
      short_en_d_reg <= 1'b0;
    end else begin
      long_en_d_reg  <= long_run_enable_reg;
      short_en_d_reg <= short_enable_reg;
      if (capture_evt) begin
        capture_reg <= count_reg;
      end
      if (long_start || capture_evt || terminal) begin
        count_reg <= reload_reg;
      end else if (long_run_enable_reg && tick && allowed) begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  // ping-pong turn passes at each terminal count; normal mode ends it
  turn_t turn_next;
  assign turn_next = (!pingpong || !long_run_enable_reg) ? TURN_SHORT :
                     (turn_reg == TURN_SHORT && short_terminal) ? TURN_LONG :
                     (turn_reg == TURN_LONG && terminal) ? TURN_SHORT : turn_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      turn_reg <= TURN_SHORT;
    end else begin
      turn_reg <= turn_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire long_out_next;
  wire short_out_next;

  assign long_out_next =
    (forced && sub_reg == SUB_FORCE_LOW)  ? 1'b0 :
    (forced && sub_reg == SUB_FORCE_HIGH) ? 1'b1 :
    demod                                 ? long_counter_output :
    !long_run_enable_reg                  ? ~long_init_or_fall_flag_reg :
    long_start                            ? long_init_or_fall_flag_reg :
    terminal                              ? ~long_counter_output : long_counter_output;

  assign short_out_next =
    demod                                 ? short_counter_output :
    !short_enable_reg                     ? ~short_init_or_rise_flag_reg :
    short_start                           ? short_init_or_rise_flag_reg :
    (short_terminal && (turn_reg == TURN_SHORT || !pingpong)) ? ~short_counter_output :
                                            short_counter_output;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      short_counter_output <= 1'b0;
      long_counter_output  <= 1'b0;
      combined_output      <= 1'b0;
      long_pin             <= 1'b0;
      capture_request      <= 1'b0;
      timeout_request      <= 1'b0;
    end else begin
      short_counter_output <= short_out_next;
      long_counter_output  <= long_out_next;
      combined_output      <= combine(sel_reg, short_out_next, long_out_next);
      long_pin             <= long_pin_output_select_reg ? long_out_next : port_data;
      capture_request      <= capture_evt & cap_mask_reg;
      timeout_request      <= timeout_reg & to_mask_reg;
    end
  end

endmodule : ir_counter_control
`default_nettype wire

// ==== ir_counter_pkg.sv ====
// constants, field positions and types for the dual infrared counter control
// assumes a 32-bit AHB-Lite register bus and one 40 MHz clock
package ir_counter_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SHORT_CTRL  = 6'h00;
  localparam logic [5:0] IDX_COMMON      = 6'h01;
  localparam logic [5:0] IDX_LONG_CTRL   = 6'h02;
  localparam logic [5:0] IDX_LONG_RELOAD = 6'h03;
  localparam logic [5:0] IDX_CAPTURE     = 6'h04;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LC_ENABLE   = 7;
  localparam int LC_SINGLE   = 6;
  localparam int LC_TIMEOUT  = 5;
  localparam int LC_PRE_LO   = 3;
  localparam int LC_CAP_MASK = 2;
  localparam int LC_TO_MASK  = 1;
  localparam int LC_PIN_SEL  = 0;
  localparam int CF_MODE     = 7;
  localparam int CF_IN_SEL   = 6;
  localparam int CF_SEL_LO   = 4;
  localparam int CF_SUB_LO   = 2;
  localparam int CF_SHORT    = 1;
  localparam int CF_LONG     = 0;
  localparam int SC_ENABLE   = 7;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  SUB_NORMAL     = 2'b00;
  localparam logic [1:0]  SUB_PINGPONG   = 2'b01;
  localparam logic [1:0]  SUB_FORCE_LOW  = 2'b10;
  localparam logic [1:0]  SUB_FORCE_HIGH = 2'b11;
  localparam logic [1:0]  EDGE_FALL      = 2'b00;
  localparam logic [1:0]  EDGE_RISE      = 2'b01;
  localparam logic [1:0]  EDGE_BOTH      = 2'b10;
  localparam logic [1:0]  PRE_RESET      = 2'b00;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] RELOAD_RESET   = 16'h00FF;
  localparam logic [3:0]  GLITCH_W0      = 4'h0;
  localparam logic [3:0]  GLITCH_W1      = 4'h2;
  localparam logic [3:0]  GLITCH_W2      = 4'h4;
  localparam logic [3:0]  GLITCH_W3      = 4'h8;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;

  typedef enum logic {TURN_SHORT = 1'b0, TURN_LONG = 1'b1} turn_t;

  // merge the two counter outputs
  function automatic logic combine(input logic [1:0] code, input logic a, input logic b);
    case (code)
      2'b00:   combine = a & b;
      2'b01:   combine = a | b;
      2'b10:   combine = ~(a | b);
      default: combine = ~(a & b);
    endcase
  endfunction : combine

endpackage : ir_counter_pkg

// ==== ir_prescaler.sv ====
// prescaler giving the long counter its count tick
// assumes select is a static register field
`timescale 1ns/100ps
`default_nettype none
module ir_prescaler (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [1:0] select,
  output var  logic       tick
);
  import ir_counter_pkg::*;

  logic [2:0] div_reg;
  wire        tick_next;

  // divide by 1, 2, 4 or 8
  assign tick_next = (select == 2'b00) ? 1'b1 :
                     (select == 2'b01) ? div_reg[0] :
                     (select == 2'b10) ? (div_reg[1:0] == 2'b11) :
                                         (div_reg == 3'h7);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 3'h0;
      tick    <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      tick    <= tick_next;
    end
  end
endmodule : ir_prescaler
`default_nettype wire

// ==== ir_edge_filter.sv ====
// glitch filter and edge detector for the demodulator input
// assumes the raw input is synchronous to clock
`timescale 1ns/100ps
`default_nettype none
module ir_edge_filter (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       raw,
  input  wire logic [1:0] width_code,
  output var  logic       rise,
  output var  logic       fall
);
  import ir_counter_pkg::*;

  logic [3:0] count_reg;
  logic       level_reg;
  wire  [3:0] width;
  wire        differs;
  wire        accept;

  // pulses no longer than width are dropped
  assign width   = (width_code == 2'b00) ? GLITCH_W0 :
                   (width_code == 2'b01) ? GLITCH_W1 :
                   (width_code == 2'b10) ? GLITCH_W2 : GLITCH_W3;
  assign differs = raw != level_reg;
  assign accept  = differs && (count_reg >= width);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 4'h0;
      level_reg <= 1'b0;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else begin
      count_reg <= (differs && !accept) ? count_reg + 4'h1 : 4'h0;
      level_reg <= accept ? raw : level_reg;
      rise      <= accept & raw;
      fall      <= accept & ~raw;
    end
  end
endmodule : ir_edge_filter
`default_nettype wire

// ==== ir_counter_control_properties.sv ====
// assertions on the ports of the dual infrared counter control
// assumes control registers change only by AHB-Lite writes and stop recovery
`timescale 1ns/100ps
`default_nettype none
module ir_counter_control_properties (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        stop_recovery,
  input wire logic        port_data,
  input wire logic        short_counter_output,
  input wire logic        long_counter_output,
  input wire logic        combined_output,
  input wire logic        long_pin,
  input wire logic        capture_request,
  input wire logic        timeout_request
);
  import ir_counter_pkg::*;
  logic [7:0]  com_reg, lc_reg;
  logic        sc_en_reg, wr_reg;
  logic [5:0]  idx_reg;
  logic [1:0]  quiet_reg;
  logic [19:0] snap_reg;
  wire  logic [19:0] snap = {com_reg, lc_reg, sc_en_reg, short_counter_output,
                             long_counter_output, port_data};
  wire  logic  calm     = (quiet_reg == 2'h3) && (snap == snap_reg);
  wire  logic  use_or   = com_reg[5] ^ com_reg[4];
  wire  logic  s_and_l  = short_counter_output & long_counter_output;
  wire  logic  s_or_l   = short_counter_output | long_counter_output;
  wire  logic  comb_ref = com_reg[5] ^ (use_or ? s_or_l : s_and_l);
  wire  logic  force_lo = !com_reg[CF_MODE] && (com_reg[3:2] == SUB_FORCE_LOW);
  wire  logic  force_hi = !com_reg[CF_MODE] && (com_reg[3:2] == SUB_FORCE_HIGH);

  // settle counter: cycles, saturating at 3, since any watched value last moved
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= 1'b0;
      idx_reg <= 6'h00;
      snap_reg <= 20'h00000;
      quiet_reg <= 2'h0;
    end else begin
      wr_reg <= hsel && hready && htrans[1] && hwrite;
      idx_reg <= haddr[7:2];
      snap_reg <= snap;
      quiet_reg <= (snap != snap_reg) ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
    end
  end

  // shadow of the control fields
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      com_reg <= 8'h00;
      lc_reg <= 8'h00;
      sc_en_reg <= 1'b0;
    end else if (stop_recovery) begin
      com_reg <= 8'h00;
      lc_reg <= lc_reg & 8'h1C;
      sc_en_reg <= 1'b0;
    end else if (wr_reg) begin
      if (idx_reg == IDX_COMMON) com_reg <= hwdata[7:0];
      if (idx_reg == IDX_LONG_CTRL) lc_reg <= hwdata[7:0];
      if (idx_reg == IDX_SHORT_CTRL) sc_en_reg <= hwdata[SC_ENABLE];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_combine; calm && !com_reg[CF_MODE] |-> combined_output == comb_ref; endproperty
  a_combine: assert property (p_combine) else $error("combined output wrong");
  property p_force_low; force_lo && $past(force_lo) |-> !long_counter_output; endproperty
  a_force_low: assert property (p_force_low) else $error("long output not low");
  property p_force_high; force_hi && $past(force_hi) |-> long_counter_output; endproperty
  a_force_high: assert property (p_force_high) else $error("long output not high");
  property p_short_idle;
    calm && !com_reg[CF_MODE] && !sc_en_reg |-> short_counter_output == !com_reg[CF_SHORT];
  endproperty
  a_short_idle: assert property (p_short_idle) else $error("idle short output wrong");
  property p_long_idle;
    calm && !com_reg[CF_MODE] && !lc_reg[LC_ENABLE] && !com_reg[3] |->
      long_counter_output == !com_reg[CF_LONG];
  endproperty
  a_long_idle: assert property (p_long_idle) else $error("idle long output wrong");
  property p_pin; calm |-> long_pin == (lc_reg[LC_PIN_SEL] ? long_counter_output : port_data); endproperty
  a_pin: assert property (p_pin) else $error("long pin source wrong");
  property p_capture;
    capture_request |-> $past(com_reg[CF_MODE]) && $past(lc_reg[LC_CAP_MASK]) && !$past(lc_reg[LC_SINGLE]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture pulse not allowed");
  property p_timeout; timeout_request |-> $past(lc_reg[LC_TO_MASK]); endproperty
  a_timeout: assert property (p_timeout) else $error("timeout request not enabled");
endmodule : ir_counter_control_properties

bind ir_counter_control ir_counter_control_properties u_props (
  .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .stop_recovery(stop_recovery), .port_data(port_data),
  .short_counter_output(short_counter_output), .long_counter_output(long_counter_output),
  .combined_output(combined_output), .long_pin(long_pin),
  .capture_request(capture_request), .timeout_request(timeout_request)
);
`default_nettype wire

// ==== dual_ir_counter_control_tb_top.sv ====
// self-checking bench for the dual infrared counter control block
// assumes a zero wait AHB-Lite slave and one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module dual_ir_counter_control_tb_top;
  import ir_counter_pkg::*;
  logic        clock, nrst, hsel, hwrite, stop_recovery, port_data, short_terminal;
  logic        demod_input_a, demod_input_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire  logic  hreadyout, hresp, sc_out, lc_out, comb_out, long_pin, cap_req, to_req;
  wire  logic [31:0] hrdata;
  int          n_errors, tests_run, cap_n;

  ir_counter_control u_dut (
    .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_recovery(stop_recovery),
    .short_terminal(short_terminal), .demod_input_a(demod_input_a),
    .demod_input_b(demod_input_b), .port_data(port_data), .short_counter_output(sc_out),
    .long_counter_output(lc_out), .combined_output(comb_out), .long_pin(long_pin),
    .capture_request(cap_req), .timeout_request(to_req)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial cap_n = 0;
  always @(posedge clock) if (cap_req === 1'b1) cap_n <= cap_n + 1;

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // one single AHB-Lite transfer, read data left in rd
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h00000000);
    check(rd, exp);
  endtask : rdc

  task automatic t_reset;
    check({hresp, sc_out, lc_out, comb_out}, 4'h7);
    rdc(IDX_LONG_CTRL, 32'h00000000);
    rdc(IDX_COMMON, 32'h00000000);
    rdc(6'h3F, 32'h00000000);
  endtask : t_reset

  task automatic t_combine;
    logic s, l, e;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) begin
        wr(IDX_COMMON, {26'h0, c[1:0], 2'b00, i[1:0]});
        tick(4);
        s = ~i[1];
        l = ~i[0];
        case (c)
          0: e = s & l;
          1: e = s | l;
          2: e = ~(s | l);
          default: e = ~(s & l);
        endcase
        check({sc_out, lc_out, comb_out}, {s, l, e});
      end
    end
  endtask : t_combine

  task automatic t_force;
    for (int i = 0; i < 2; i++) begin
      wr(IDX_COMMON, {28'h0, SUB_FORCE_LOW, 1'b0, i[0]});
      tick(1);
      check(lc_out, 1'b0);
      wr(IDX_COMMON, {28'h0, SUB_FORCE_HIGH, 1'b0, i[0]});
      tick(1);
      check(lc_out, 1'b1);
    end
  endtask : t_force

  task automatic t_long;
    int n;
    wr(IDX_COMMON, 32'h01);
    wr(IDX_LONG_RELOAD, 32'h10);
    wr(IDX_LONG_CTRL, 32'hDA);
    tick(2);
    check(lc_out, 1'b1);
    rdc(IDX_LONG_CTRL, 32'hDA);
    n = 0;
    do begin
      bus(IDX_LONG_CTRL, 1'b0, 32'h0);
      n++;
    end while (rd[7] !== 1'b0 && n < 200);
    check(rd, 32'h7A);
    tick(2);
    check(to_req, 1'b1);
    wr(IDX_LONG_CTRL, 32'h5A);
    rdc(IDX_LONG_CTRL, 32'h7A);
    wr(IDX_LONG_CTRL, 32'h7A);
    rdc(IDX_LONG_CTRL, 32'h5A);
    tick(2);
    check(to_req, 1'b0);
    wr(IDX_LONG_CTRL, 32'h80);
    tick(40);
    rdc(IDX_LONG_CTRL, 32'hA0);
    wr(IDX_LONG_CTRL, 32'h20);
    rdc(IDX_LONG_CTRL, 32'h00);
  endtask : t_long

  task automatic t_pin_stop;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_LONG_CTRL, {31'h0, i[1]});
      port_data <= i[0];
      tick(3);
      check(long_pin, i[1] ? 1'b0 : i[0]);
      wr(IDX_LONG_CTRL, {27'h0, i[1:0], 3'b101});
      rdc(IDX_LONG_CTRL, {27'h0, i[1:0], 3'b101});
    end
    wr(IDX_COMMON, 32'h3D);
    stop_recovery <= 1'b1;
    tick(1);
    stop_recovery <= 1'b0;
    rdc(IDX_LONG_CTRL, 32'h1C);
    rdc(IDX_COMMON, 32'h00);
  endtask : t_pin_stop

  task automatic t_pingpong;
    wr(IDX_LONG_RELOAD, 32'h2);
    wr(IDX_COMMON, 32'h04);
    wr(IDX_SHORT_CTRL, 32'h80);
    tick(2);
    check(sc_out, 1'b0);
    wr(IDX_LONG_CTRL, 32'h80);
    tick(8);
    check(lc_out, 1'b0);
    rdc(IDX_LONG_CTRL, 32'h80);
    short_terminal <= 1'b1;
    tick(1);
    short_terminal <= 1'b0;
    tick(8);
    check({sc_out, lc_out, comb_out}, 3'b111);
    rdc(IDX_LONG_CTRL, 32'hA0);
    wr(IDX_LONG_CTRL, 32'hA0);
    wr(IDX_COMMON, 32'h00);
    tick(10);
    rdc(IDX_LONG_CTRL, 32'hA0);
    wr(IDX_SHORT_CTRL, 32'h00);
    wr(IDX_LONG_CTRL, 32'h00);
  endtask : t_pingpong

  task automatic edge_case(input logic [7:0] cfg, input int len, input int nr, input int nf,
                           input logic use_b);
    int base;
    wr(IDX_COMMON, {24'h0, cfg});
    tick(4);
    base = cap_n;
    if (use_b) demod_input_b <= 1'b1;
    else demod_input_a <= 1'b1;
    tick(len);
    check(cap_n - base, nr);
    demod_input_a <= 1'b0;
    demod_input_b <= 1'b0;
    tick(20);
    check(cap_n - base, nf);
  endtask : edge_case

  task automatic t_demod;
    wr(IDX_LONG_RELOAD, 32'h100);
    rdc(IDX_LONG_RELOAD, 32'h100);
    wr(IDX_COMMON, 32'hA0);
    wr(IDX_LONG_CTRL, 32'h84);
    edge_case(8'hA0, 20, 1, 2, 1'b0);
    rdc(IDX_COMMON, 32'hA3);
    wr(IDX_COMMON, 32'hA1);
    rdc(IDX_COMMON, 32'hA2);
    wr(IDX_COMMON, 32'hA2);
    rdc(IDX_COMMON, 32'hA0);
    edge_case(8'h80, 20, 0, 1, 1'b0);
    edge_case(8'h90, 20, 1, 1, 1'b0);
    edge_case(8'hB0, 20, 0, 0, 1'b0);
    edge_case(8'hE0, 20, 1, 2, 1'b1);
    edge_case(8'hAC, 4, 0, 0, 1'b0);
    edge_case(8'hAC, 20, 1, 2, 1'b0);
    wr(IDX_LONG_CTRL, 32'hC4);
    edge_case(8'hA0, 20, 0, 0, 1'b0);
    wr(IDX_LONG_CTRL, 32'h80);
    edge_case(8'hA0, 20, 0, 0, 1'b0);
  endtask : t_demod

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    stop_recovery = 1'b0;
    short_terminal = 1'b0;
    demod_input_a = 1'b0;
    demod_input_b = 1'b0;
    port_data = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    tick(2);
    t_reset;
    t_combine;
    t_force;
    t_long;
    t_pin_stop;
    t_pingpong;
    t_demod;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test;
  end
endmodule : dual_ir_counter_control_tb_top
`default_nettype wire
